// [rtl/power_ctl_pkg.sv]
// Package with register map, field positions and reset values of the power output control block.
// Assumes an APB slave with 32-bit data; registers sit in the low byte of aligned words.
package power_ctl_pkg;
  // Printed offsets are not all multiples of four, so they are indices; byte address is four times the index.
  localparam logic [7:0] IDX_HALF_BRIDGE_OUT  = 8'h01;
  localparam logic [7:0] IDX_BRIDGE_CONTROL   = 8'h02;
  localparam logic [7:0] IDX_SYSTEM_CONTROL   = 8'h03;
  localparam logic [7:0] IDX_POWER_OUTPUT     = 8'h04;
  localparam logic [7:0] IDX_INTERRUPT_FLAG   = 8'h05;
  localparam logic [7:0] IDX_SYSTEM_STATUS    = 8'h0c;
  localparam logic [7:0] RESET_BYTE           = 8'h00;
  // Bridge control fields.
  localparam int         BIT_OFFSET_CHOP      = 7;
  localparam int         BIT_SENSE_GAIN       = 6;
  localparam int         LIMIT_LSB            = 0;
  localparam int         LIMIT_W              = 3;
  localparam logic [2:0] LIMIT_FIRST_ACTIVE   = 3'h3;
  // System control fields.
  localparam int         BIT_POWER_STAGE      = 7;
  localparam int         BIT_OVERTEMP_RESET   = 0;
  // Power output fields.
  localparam int         BIT_LAMP_ON          = 1;
  localparam int         BIT_SUPPLY_ON        = 0;
  // Interrupt flag fields.
  localparam int         BIT_LOW_VOLTAGE      = 1;
  localparam int         BIT_HIGH_VOLTAGE     = 0;
  // System status fields.
  localparam int         BIT_SUPPLY_OCF       = 5;
  localparam int         BIT_LAMP_OCF         = 4;
  localparam int         BIT_LV_COPY          = 3;
  localparam int         BIT_HV_COPY          = 2;
  localparam int         BIT_BRIDGE_OCF       = 1;
  localparam int         BIT_OVERTEMP_WARN    = 0;
  localparam int         NUM_BRIDGES          = 4;
endpackage : power_ctl_pkg

// [rtl/pin_sync.sv]
// Three-stage synchroniser for one asynchronous input with agreement filtering.
// Assumes the input is a level from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  input  wire logic CLOCK_I,
  input  wire logic RESET_I,
  input  wire logic PIN_I,
  output logic      LEVEL_O
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // The first stage feeds only the second; the level moves once stages two and three agree.
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = PIN_I;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.level = st_r.s3;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign LEVEL_O = st_r.level;
endmodule : pin_sync
`default_nettype wire

// [rtl/power_output_protection_control.sv]
// Power output control and protection for four half-bridges, a lamp switch and a switched supply.
// Assumes an APB master on CLOCK_I and comparator inputs that arrive asynchronously.
// What this block does
// - Low switch off above selected limit
// - Limited low switch resumes on chop rise
// - Offset chop: bridges 3-4 resume on fall
// - Sense gain bit selects measurement range
// - Recirculation output follows detected recirculation
// - Overtemp with reset enabled kills outputs
// - High-side overcurrent kills all high switches
// - Low-side overcurrent kills all low switches
// - Write one clears bridge overcurrent flag
// - Voltage flags disable all half-bridges
// - Voltage flags clear by one, persist
// - Voltage flags disable lamp output
// - Limit codes below three mean none
// - Lamp needs stage enable and on bit
// - Lamp overcurrent switches off, sets flag
// - Lamp re-enabled on each chop rise
// - Write one clears lamp overcurrent flag
// - Supply needs enable and on bit only
// - Supply overtemp only with reset enabled
// - Supply overcurrent switches off, sets flag
// - Stage enable low holds all switches, lamp and supply off
// - Both bits set: only high switch on
// - Writing zero to overcurrent flag: no effect
`timescale 1ns/10ps
`default_nettype none
module power_output_protection_control #(
  parameter int NB = power_ctl_pkg::NUM_BRIDGES
) (
  input  wire logic          CLOCK_I,
  input  wire logic          RESET_I,
  input  wire logic          PSEL_I,
  input  wire logic          PENABLE_I,
  input  wire logic          PWRITE_I,
  input  wire logic [11:0]   PADDR_I,
  input  wire logic [31:0]   PWDATA_I,
  output logic      [31:0]   PRDATA_O,
  output logic               PREADY_O,
  output logic               PSLVERR_O,
  input  wire logic          CHOP_CLOCK_INPUT_I,
  input  wire logic [NB-1:0] LIMIT_EXCEEDED_I,
  input  wire logic          HIGH_OVERCURRENT_I,
  input  wire logic          LOW_OVERCURRENT_I,
  input  wire logic [NB-1:0] RECIRCULATION_I,
  input  wire logic          LOW_VOLTAGE_I,
  input  wire logic          HIGH_VOLTAGE_I,
  input  wire logic          OVERTEMP_WARN_I,
  input  wire logic          OVERTEMP_TRIP_I,
  input  wire logic          LAMP_OVERCURRENT_I,
  input  wire logic          SUPPLY_OVERCURRENT_I,
  output logic      [NB-1:0] HIGH_SWITCH_O,
  output logic      [NB-1:0] LOW_SWITCH_O,
  output logic               LAMP_OUTPUT_O,
  output logic               SWITCHED_SUPPLY_OUTPUT_O,
  output logic               SENSE_GAIN_SELECT_O,
  output logic      [2:0]    LIMIT_SELECT_O,
  output logic               LIMIT_ACTIVE_O,
  output logic               RECIRCULATION_DETECT_O,
  output logic               OVERTEMP_RESET_O
);
  localparam int NS = 2 * NB + 9;

  typedef struct packed {
    logic [7:0]    half_bridge_out;
    logic [7:0]    bridge_control;
    logic [7:0]    system_control;
    logic [7:0]    power_output;
    logic          low_voltage_flag;
    logic          high_voltage_flag;
    logic          overtemp_warning_flag;
    logic          bridge_overcurrent_flag;
    logic          high_trip;
    logic          low_trip;
    logic          lamp_overcurrent_flag;
    logic          switched_supply_overcurrent_flag;
    logic [NB-1:0] limit_off;
    logic          lamp_chop_off;
    logic          chop_prev;
    logic          overtemp_reset;
    logic [31:0]   rdata;
    logic [NB-1:0] high_sw;
    logic [NB-1:0] low_sw;
    logic          lamp;
    logic          supply;
    logic          recirc;
  } ctl_state_t;

  ctl_state_t st_r;
  ctl_state_t st_nxt;

  logic [NS-1:0] raw_in;
  logic [NS-1:0] syn;

  ////////////////////////////////////////////////////////////////////////////////
  // Every asynchronous comparator and the chop clock pass a synchroniser.
  assign raw_in = {CHOP_CLOCK_INPUT_I, LIMIT_EXCEEDED_I, HIGH_OVERCURRENT_I, LOW_OVERCURRENT_I,
                   RECIRCULATION_I, LOW_VOLTAGE_I, HIGH_VOLTAGE_I, OVERTEMP_WARN_I, OVERTEMP_TRIP_I,
                   LAMP_OVERCURRENT_I, SUPPLY_OVERCURRENT_I};

  for (genvar g = 0; g < NS; g++) begin : g_sync
    pin_sync u_sync (
      .CLOCK_I (CLOCK_I),
      .RESET_I (RESET_I),
      .PIN_I   (raw_in[g]),
      .LEVEL_O (syn[g])
    );
  end

  logic          s_chop;
  logic [NB-1:0] s_limit;
  logic          s_hi_oc;
  logic          s_lo_oc;
  logic [NB-1:0] s_recirc;
  logic          s_lv;
  logic          s_hv;
  logic          s_ot_warn;
  logic          s_ot_trip;
  logic          s_lamp_oc;
  logic          s_sup_oc;
  assign {s_chop, s_limit, s_hi_oc, s_lo_oc, s_recirc, s_lv, s_hv, s_ot_warn, s_ot_trip, s_lamp_oc,
          s_sup_oc} = syn;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  logic       wr;
  logic       rd_setup;
  logic [7:0] idx;
  logic [7:0] wb;
  logic       mapped;
  assign idx    = PADDR_I[9:2];
  assign wb     = PWDATA_I[7:0];
  assign wr     = PSEL_I & PENABLE_I & PWRITE_I & mapped;
  assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I & mapped;
  assign mapped = (PADDR_I[1:0] == 2'h0) && (PADDR_I[11:10] == 2'h0) &&
                  ((idx == power_ctl_pkg::IDX_HALF_BRIDGE_OUT) || (idx == power_ctl_pkg::IDX_BRIDGE_CONTROL) ||
                   (idx == power_ctl_pkg::IDX_SYSTEM_CONTROL) || (idx == power_ctl_pkg::IDX_POWER_OUTPUT) ||
                   (idx == power_ctl_pkg::IDX_INTERRUPT_FLAG) || (idx == power_ctl_pkg::IDX_SYSTEM_STATUS));

  logic [7:0] status_byte;
  logic [7:0] irq_byte;
  always_comb begin
    status_byte = 8'h00;
    status_byte[power_ctl_pkg::BIT_SUPPLY_OCF]    = st_r.switched_supply_overcurrent_flag;
    status_byte[power_ctl_pkg::BIT_LAMP_OCF]      = st_r.lamp_overcurrent_flag;
    status_byte[power_ctl_pkg::BIT_LV_COPY]       = st_r.low_voltage_flag;
    status_byte[power_ctl_pkg::BIT_HV_COPY]       = st_r.high_voltage_flag;
    status_byte[power_ctl_pkg::BIT_BRIDGE_OCF]    = st_r.bridge_overcurrent_flag;
    status_byte[power_ctl_pkg::BIT_OVERTEMP_WARN] = st_r.overtemp_warning_flag;
    irq_byte = 8'h00;
    irq_byte[power_ctl_pkg::BIT_LOW_VOLTAGE]      = st_r.low_voltage_flag;
    irq_byte[power_ctl_pkg::BIT_HIGH_VOLTAGE]     = st_r.high_voltage_flag;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Protection and output logic.
  logic          stage_on;
  logic          voltage_bad;
  logic          chop_rise;
  logic          chop_fall;
  logic          limit_on;
  logic [NB-1:0] resume;
  logic          wr_status;
  logic          wr_irq;

  assign stage_on    = st_r.system_control[power_ctl_pkg::BIT_POWER_STAGE];
  assign voltage_bad = st_r.low_voltage_flag | st_r.high_voltage_flag;
  assign chop_rise   = s_chop & ~st_r.chop_prev;
  assign chop_fall   = ~s_chop & st_r.chop_prev;
  // Codes under the first active one mean no limiting at all.
  assign limit_on    = st_r.bridge_control[power_ctl_pkg::LIMIT_LSB +: power_ctl_pkg::LIMIT_W] >=
                       power_ctl_pkg::LIMIT_FIRST_ACTIVE;
  assign wr_status   = wr && (idx == power_ctl_pkg::IDX_SYSTEM_STATUS);
  assign wr_irq      = wr && (idx == power_ctl_pkg::IDX_INTERRUPT_FLAG);

  always_comb begin
    for (int b = 0; b < NB; b++) begin
      if (st_r.bridge_control[power_ctl_pkg::BIT_OFFSET_CHOP] && b >= 2) begin
        resume[b] = chop_fall;
      end else begin
        resume[b] = chop_rise;
      end
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.chop_prev = s_chop;
    st_nxt.rdata     = 32'h0000_0000;
    if (rd_setup) begin
      if (idx == power_ctl_pkg::IDX_HALF_BRIDGE_OUT) begin
        st_nxt.rdata[7:0] = st_r.half_bridge_out;
      end else if (idx == power_ctl_pkg::IDX_BRIDGE_CONTROL) begin
        st_nxt.rdata[7:0] = st_r.bridge_control & 8'hc7;
      end else if (idx == power_ctl_pkg::IDX_SYSTEM_CONTROL) begin
        st_nxt.rdata[7:0] = st_r.system_control;
      end else if (idx == power_ctl_pkg::IDX_POWER_OUTPUT) begin
        st_nxt.rdata[7:0] = st_r.power_output;
      end else if (idx == power_ctl_pkg::IDX_INTERRUPT_FLAG) begin
        st_nxt.rdata[7:0] = irq_byte;
      end else if (idx == power_ctl_pkg::IDX_SYSTEM_STATUS) begin
        st_nxt.rdata[7:0] = status_byte;
      end
    end
    if (wr) begin
      if (idx == power_ctl_pkg::IDX_HALF_BRIDGE_OUT) begin
        st_nxt.half_bridge_out = wb;
      end else if (idx == power_ctl_pkg::IDX_BRIDGE_CONTROL) begin
        st_nxt.bridge_control = wb & 8'hc7;
      end else if (idx == power_ctl_pkg::IDX_SYSTEM_CONTROL) begin
        st_nxt.system_control = wb & 8'h81;
      end else if (idx == power_ctl_pkg::IDX_POWER_OUTPUT) begin
        st_nxt.power_output = wb & 8'h03;
      end
    end
    // Clears come first so that an event in the same cycle still sets the flag.
    if (wr_status && wb[power_ctl_pkg::BIT_BRIDGE_OCF]) begin
      st_nxt.bridge_overcurrent_flag = 1'b0;
      st_nxt.high_trip               = 1'b0;
      st_nxt.low_trip                = 1'b0;
    end
    if (wr_status && wb[power_ctl_pkg::BIT_LAMP_OCF]) begin
      st_nxt.lamp_overcurrent_flag = 1'b0;
    end
    if (wr_status && wb[power_ctl_pkg::BIT_SUPPLY_OCF]) begin
      st_nxt.switched_supply_overcurrent_flag = 1'b0;
    end
    if (wr_irq && wb[power_ctl_pkg::BIT_LOW_VOLTAGE]) begin
      st_nxt.low_voltage_flag = 1'b0;
    end
    if (wr_irq && wb[power_ctl_pkg::BIT_HIGH_VOLTAGE]) begin
      st_nxt.high_voltage_flag = 1'b0;
    end
    // One shared flag, but each side remembers its own trip so the other side keeps running.
    if (s_hi_oc) begin
      st_nxt.bridge_overcurrent_flag = 1'b1;
      st_nxt.high_trip               = 1'b1;
    end
    if (s_lo_oc) begin
      st_nxt.bridge_overcurrent_flag = 1'b1;
      st_nxt.low_trip                = 1'b1;
    end
    if (s_lamp_oc) begin
      st_nxt.lamp_overcurrent_flag = 1'b1;
    end
    if (s_sup_oc) begin
      st_nxt.switched_supply_overcurrent_flag = 1'b1;
    end
    if (s_lv) begin
      st_nxt.low_voltage_flag = 1'b1;
    end
    if (s_hv) begin
      st_nxt.high_voltage_flag = 1'b1;
    end
    st_nxt.overtemp_warning_flag = s_ot_warn;
    // Current-limit chopping: off on excess, back on at the chosen chop edge.
    for (int b = 0; b < NB; b++) begin
      if (limit_on && s_limit[b]) begin
        st_nxt.limit_off[b] = 1'b1;
      end else if (resume[b] || !limit_on) begin
        st_nxt.limit_off[b] = 1'b0;
      end
    end
    // Lamp chopping keeps bulb inrush at the shutdown limit instead of latching off.
    if (s_lamp_oc) begin
      st_nxt.lamp_chop_off = 1'b1;
    end else if (chop_rise) begin
      st_nxt.lamp_chop_off = 1'b0;
    end
    st_nxt.overtemp_reset = st_r.system_control[power_ctl_pkg::BIT_OVERTEMP_RESET] && s_ot_trip;
    // Switch outputs.
    for (int b = 0; b < NB; b++) begin
      st_nxt.high_sw[b] = st_r.half_bridge_out[2*b+1] && stage_on && !voltage_bad &&
                          !st_r.high_trip && !st_r.overtemp_reset;
      st_nxt.low_sw[b]  = st_r.half_bridge_out[2*b] && !st_r.half_bridge_out[2*b+1] && stage_on &&
                          !voltage_bad && !st_r.low_trip && !st_r.limit_off[b] &&
                          !st_r.overtemp_reset;
    end
    st_nxt.lamp   = stage_on && st_r.power_output[power_ctl_pkg::BIT_LAMP_ON] && !voltage_bad &&
                    !st_r.lamp_chop_off && !st_r.overtemp_reset;
    st_nxt.supply = stage_on && st_r.power_output[power_ctl_pkg::BIT_SUPPLY_ON] &&
                    !st_r.switched_supply_overcurrent_flag && !st_r.overtemp_reset;
    st_nxt.recirc = |s_recirc;
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PRDATA_O                 = st_r.rdata;
  assign PREADY_O                 = 1'b1;
  assign PSLVERR_O                = PSEL_I & PENABLE_I & ~mapped;
  assign HIGH_SWITCH_O            = st_r.high_sw;
  assign LOW_SWITCH_O             = st_r.low_sw;
  assign LAMP_OUTPUT_O            = st_r.lamp;
  assign SWITCHED_SUPPLY_OUTPUT_O = st_r.supply;
  assign SENSE_GAIN_SELECT_O      = st_r.bridge_control[power_ctl_pkg::BIT_SENSE_GAIN];
  assign LIMIT_SELECT_O           = st_r.bridge_control[2:0];
  assign LIMIT_ACTIVE_O           = limit_on;
  assign RECIRCULATION_DETECT_O   = st_r.recirc;
  assign OVERTEMP_RESET_O         = st_r.overtemp_reset;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  property p_low_off_stage;
    @(posedge CLOCK_I) disable iff (RESET_I)
      !stage_on |=> (LOW_SWITCH_O == '0) && !LAMP_OUTPUT_O && !SWITCHED_SUPPLY_OUTPUT_O;
  endproperty
  a_low_off_stage: assert property (p_low_off_stage) else $error("Outputs on without stage enable.");
  property p_priority;
    @(posedge CLOCK_I) disable iff (RESET_I) (HIGH_SWITCH_O & LOW_SWITCH_O) == '0;
  endproperty
  a_priority: assert property (p_priority) else $error("Both switches of a bridge on.");
  property p_ocf_set;
    @(posedge CLOCK_I) disable iff (RESET_I)
      s_hi_oc |=> st_r.bridge_overcurrent_flag ##1 (HIGH_SWITCH_O == '0);
  endproperty
  a_ocf_set: assert property (p_ocf_set) else $error("High side overcurrent not handled.");
  property p_ocf_low;
    @(posedge CLOCK_I) disable iff (RESET_I)
      s_lo_oc |=> st_r.bridge_overcurrent_flag ##1 (LOW_SWITCH_O == '0);
  endproperty
  a_ocf_low: assert property (p_ocf_low) else $error("Low side overcurrent not handled.");
  property p_ocf_zero;
    @(posedge CLOCK_I) disable iff (RESET_I)
      st_r.bridge_overcurrent_flag && !(wr_status && wb[power_ctl_pkg::BIT_BRIDGE_OCF]) |=>
      st_r.bridge_overcurrent_flag;
  endproperty
  a_ocf_zero: assert property (p_ocf_zero) else $error("Bridge flag cleared without a one.");
  property p_volt;
    @(posedge CLOCK_I) disable iff (RESET_I) voltage_bad |=> !LAMP_OUTPUT_O && HIGH_SWITCH_O == '0;
  endproperty
  a_volt: assert property (p_volt) else $error("Output on during voltage fault.");
  property p_lv_persist;
    @(posedge CLOCK_I) disable iff (RESET_I) s_lv |=> st_r.low_voltage_flag;
  endproperty
  a_lv_persist: assert property (p_lv_persist) else $error("Low voltage flag lost.");
  property p_lamp_flag;
    @(posedge CLOCK_I) disable iff (RESET_I) s_lamp_oc |=> st_r.lamp_overcurrent_flag ##1 !LAMP_OUTPUT_O;
  endproperty
  a_lamp_flag: assert property (p_lamp_flag) else $error("Lamp overcurrent not handled.");
  property p_recirc;
    @(posedge CLOCK_I) disable iff (RESET_I) RECIRCULATION_DETECT_O == ($past(s_recirc) != '0);
  endproperty
  a_recirc: assert property (p_recirc) else $error("Recirculation output wrong.");
  property p_limit_off;
    @(posedge CLOCK_I) disable iff (RESET_I) (limit_on && s_limit[0]) |=> ##1 !LOW_SWITCH_O[0];
  endproperty
  a_limit_off: assert property (p_limit_off) else $error("Low switch stays on above limit.");
  c_chop: cover property (@(posedge CLOCK_I) disable iff (RESET_I) st_r.limit_off[0] ##1 !st_r.limit_off[0]);
  c_ocf: cover property (@(posedge CLOCK_I) disable iff (RESET_I) st_r.bridge_overcurrent_flag ##1 !st_r.bridge_overcurrent_flag);
  c_lamp: cover property (@(posedge CLOCK_I) disable iff (RESET_I) st_r.lamp_chop_off ##1 LAMP_OUTPUT_O);
endmodule : power_output_protection_control
`default_nettype wire

// [sim/power_stage_model.sv]
// Behavioural model of the power stages and loads that sit behind the control block.
// Assumes the testbench picks the load conditions and the block drives the gate commands.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module power_stage_model (
  input  wire logic [3:0] high_sw_i,
  input  wire logic [3:0] low_sw_i,
  input  wire logic       lamp_i,
  input  wire logic       supply_i,
  input  wire logic [7:0] load_i,
  output wire logic [7:0] sense_o
);
  // A comparator only sees current while its switch conducts, so it drops once the block has switched
  // off; a model that held it up would hide a re-arm that never happens.
  assign sense_o = {load_i[7] & supply_i, load_i[6] & lamp_i, load_i[5] & (|low_sw_i),
                    load_i[4] & (|high_sw_i), load_i[3:0] & low_sw_i};
endmodule : power_stage_model
`default_nettype wire

// [sim/test_power_output_protection_control.sv]
// Self-checking testbench of the power output control block: APB tasks and protection scenarios.
// Assumes the design package is compiled first and the load model stands in for the power stages.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module test_power_output_protection_control;
  logic        clk, rst, psel, pen, pwr, chop, pready, pslverr, rerr;
  logic        lamp, sup, gain, lact, recd, otr;
  logic [2:0]  lsel;
  logic [3:0]  hsw, lsw, rq, mon;
  logic [7:0]  cmd, sense;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  int          n_fail = 0;
  int          checks = 0;
  localparam logic [7:0]  BC  = power_ctl_pkg::IDX_BRIDGE_CONTROL;
  localparam logic [7:0]  SC  = power_ctl_pkg::IDX_SYSTEM_CONTROL;
  localparam logic [7:0]  IFL = power_ctl_pkg::IDX_INTERRUPT_FLAG;
  localparam logic [7:0]  SS  = power_ctl_pkg::IDX_SYSTEM_STATUS;
  // Outputs {high, low, lamp, supply, recirculation, overtemp reset} with every stage switched on.
  localparam logic [11:0] ON  = 12'h69c;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  power_output_protection_control DUT (
    .CLOCK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .CHOP_CLOCK_INPUT_I(chop), .LIMIT_EXCEEDED_I(sense[3:0]), .HIGH_OVERCURRENT_I(sense[4]),
    .LOW_OVERCURRENT_I(sense[5]), .RECIRCULATION_I(rq), .LOW_VOLTAGE_I(mon[0]), .HIGH_VOLTAGE_I(mon[1]),
    .OVERTEMP_WARN_I(mon[2]), .OVERTEMP_TRIP_I(mon[3]), .LAMP_OVERCURRENT_I(sense[6]),
    .SUPPLY_OVERCURRENT_I(sense[7]), .HIGH_SWITCH_O(hsw), .LOW_SWITCH_O(lsw), .LAMP_OUTPUT_O(lamp),
    .SWITCHED_SUPPLY_OUTPUT_O(sup), .SENSE_GAIN_SELECT_O(gain), .LIMIT_SELECT_O(lsel),
    .LIMIT_ACTIVE_O(lact), .RECIRCULATION_DETECT_O(recd), .OVERTEMP_RESET_O(otr)
  );
  power_stage_model loads (
    .high_sw_i(hsw), .low_sw_i(lsw), .lamp_i(lamp), .supply_i(sup), .load_i(cmd), .sense_o(sense)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int k = 0;
    @(posedge clk);
    {psel, pwr, paddr, pwdata} <= {1'b1, w, 2'b00, idx, 2'b00, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      n_fail++;
      final_report();
    end
    rdat = prdata;
    rerr = pslverr;
    {psel, pen} <= 2'b00;
  endtask : apb

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rdat, exp);
  endtask : rd

  // Eight cycles cover the six that an input needs to pass the synchroniser and reach the outputs.
  task automatic look(input logic [11:0] exp);
    repeat (8) @(posedge clk);
    chk({hsw, lsw, lamp, sup, recd, otr}, exp);
  endtask : look

  // Edges stand half a period of the fastest preferred chopping rate apart.
  task automatic chop_to(input logic v);
    repeat (625) @(posedge clk);
    chop <= v;
  endtask : chop_to
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, pen, pwr, chop, cmd, rq, mon, paddr, pwdata} = '0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    look(12'h000);
    for (int i = 1; i < 6; i++) rd(i[7:0], 32'h0000_0000);
    rd(SS, 32'h0000_0000);
    apb(1'b1, 8'h06, 32'h0000_00ff);
    chk(rerr, 1'b1);
    rd(8'h06, 32'h0000_0000);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, BC, {24'h00_0000, 1'b0, c[0], 3'h7, c[2:0]});
      rd(BC, {24'h00_0000, 1'b0, c[0], 3'h0, c[2:0]});
      chk({gain, lsel, lact}, {c[0], c[2:0], c > 2});
    end
    apb(1'b1, power_ctl_pkg::IDX_HALF_BRIDGE_OUT, 32'h0000_0079);
    apb(1'b1, power_ctl_pkg::IDX_POWER_OUTPUT, 32'h0000_0003);
    look(12'h000);
    apb(1'b1, SC, 32'h0000_0080);
    look(ON);
    cmd <= 8'h01;
    look(12'h68c);
    cmd <= 8'h00;
    look(12'h68c);
    chop_to(1'b1);
    look(ON);
    apb(1'b1, BC, 32'h0000_0083);
    chop_to(1'b0);
    cmd <= 8'h08;
    look(12'h61c);
    cmd <= 8'h00;
    chop_to(1'b1);
    look(12'h61c);
    chop_to(1'b0);
    look(ON);
    rq <= 4'h4;
    look(12'h69e);
    rq <= 4'h0;
    look(ON);
    for (int k = 0; k < 2; k++) begin
      cmd <= 8'h10 << k;
      look(k ? 12'h60c : 12'h09c);
      cmd <= 8'h00;
      apb(1'b1, SS, 32'h0000_0000);
      look(k ? 12'h60c : 12'h09c);
      rd(SS, 32'h0000_0002);
      apb(1'b1, SS, 32'h0000_0002);
      look(ON);
    end
    for (int v = 0; v < 2; v++) begin
      mon <= 4'h1 << v;
      look(12'h004);
      apb(1'b1, IFL, 32'h0000_00ff);
      look(12'h004);
      rd(IFL, v ? 32'h0000_0001 : 32'h0000_0002);
      mon <= 4'h0;
      look(12'h004);
      apb(1'b1, IFL, 32'h0000_00ff);
      look(ON);
    end
    cmd <= 8'h40;
    look(12'h694);
    rd(SS, 32'h0000_0010);
    chop_to(1'b1);
    for (int t = 0; t < 12 && lamp !== 1'b1; t++) @(posedge clk);
    chk(lamp, 1'b1);
    cmd <= 8'h00;
    chop_to(1'b0);
    chop_to(1'b1);
    look(ON);
    rd(SS, 32'h0000_0010);
    apb(1'b1, SS, 32'h0000_0010);
    rd(SS, 32'h0000_0000);
    cmd <= 8'h80;
    look(12'h698);
    cmd <= 8'h00;
    rd(SS, 32'h0000_0020);
    apb(1'b1, SS, 32'h0000_0020);
    look(ON);
    mon <= 4'h4;
    look(ON);
    rd(SS, 32'h0000_0001);
    mon <= 4'h8;
    look(ON);
    apb(1'b1, SC, 32'h0000_0081);
    look(12'h001);
    final_report();
  end
endmodule : test_power_output_protection_control
`default_nettype wire
